/* File: hw/fsr_pkg.sv */
// constants and types shared by the suspend/resume controller
`default_nettype none

package fsr_pkg;

    // -------------------------------------------------------------
    // command codes (plain defaults)
    // -------------------------------------------------------------
    localparam logic [7:0] OPC_WRDI   = 8'h04;
    localparam logic [7:0] OPC_WREN   = 8'h06;
    localparam logic [7:0] OPC_WRENV  = 8'h50;
    localparam logic [7:0] OPC_STAT1  = 8'h05;
    localparam logic [7:0] OPC_STAT2  = 8'h07;
    localparam logic [7:0] OPC_CFG1   = 8'h35;
    localparam logic [7:0] OPC_LOCKB  = 8'ha7;
    localparam logic [7:0] OPC_PROG   = 8'h02;
    localparam logic [7:0] OPC_SPROG  = 8'h42;
    localparam logic [7:0] OPC_SREAD  = 8'h4b;
    localparam logic [7:0] OPC_READ   = 8'h03;
    localparam logic [7:0] OPC_DYBRD  = 8'he0;
    localparam logic [7:0] OPC_SERASE = 8'hd8;
    localparam logic [7:0] OPC_CERASE = 8'h60;
    localparam logic [7:0] OPC_CHECK  = 8'h5b;
    localparam logic [7:0] OPC_REGWR  = 8'h71;
    localparam logic [7:0] OPC_PLERA  = 8'he4;
    localparam logic [7:0] OPC_SUSP   = 8'h75;
    localparam logic [7:0] OPC_RESUME = 8'h7a;

    // -------------------------------------------------------------
    // frame layout and status fields
    // -------------------------------------------------------------
    localparam int          OPC_BITS   = 8;
    localparam int          ADDR_BITS  = 24;
    localparam logic [5:0]  FRAME_BITS = 6'h20;
    localparam int          ST1_BUSY   = 0;
    localparam int          ST2_PROG   = 0;
    localparam int          ST2_ERASE  = 1;
    localparam int          ST2_CHECK  = 4;
    localparam logic [7:0]  STAT_RST   = 8'h00;

    // -------------------------------------------------------------
    // timing
    // -------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int SUSP_LAT_NS   = 40000;

    // -------------------------------------------------------------
    // types
    // -------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01,
        ST_STOP = 2'b10
    } fsr_state_t;

    typedef enum logic [2:0] {
        OP_NONE   = 3'b000,
        OP_PROG   = 3'b001,
        OP_SERASE = 3'b010,
        OP_CERASE = 3'b011,
        OP_CHECK  = 3'b100
    } fsr_op_t;

endpackage : fsr_pkg

`default_nettype wire

/* File: hw/fsr_ctrl.sv */
// suspend/resume sequencer with serial command capture
`default_nettype none

module fsr_ctrl
    import fsr_pkg::*;
#(
    parameter int SUSP_LAT_CYC = SUSP_LAT_NS / CLK_PERIOD_NS,
    parameter int PAGE_BITS    = 8,
    parameter int SECT_BITS    = 18
) (
    // core clock and reset
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    // serial link
    input  wire logic        lnk_sck_i,
    input  wire logic        lnk_cs_n_i,
    input  wire logic        lnk_si_i,
    // array engine
    input  wire logic        op_done_i,
    output logic             engine_run_o,
    output logic             engine_halt_o,
    output logic [2:0]       engine_kind_o,
    output logic [23:0]      engine_addr_o,
    // command results
    output logic             cmd_taken_o,
    output logic             cmd_refused_o,
    output logic [7:0]       cmd_code_o,
    output logic             read_undefined_o,
    // status
    output logic [7:0]       first_status_volatile_o,
    output logic [7:0]       second_status_volatile_o
);

    // -------------------------------------------------------------
    // link domain: shift in opcode and address
    // -------------------------------------------------------------
    logic [31:0] lnk_sh_q;
    logic [5:0]  lnk_cnt_q;
    logic [5:0]  lnk_len_q;

    // counter restarts with every frame, ended by the frame's own select
    always_ff @(posedge lnk_sck_i or posedge lnk_cs_n_i) begin
        if (lnk_cs_n_i) begin
            lnk_cnt_q <= 6'h00;
        end else if (lnk_cnt_q != FRAME_BITS) begin
            lnk_cnt_q <= lnk_cnt_q + 6'h01;
        end
    end

    always_ff @(posedge lnk_sck_i) begin
        if (!lnk_cs_n_i && lnk_cnt_q != FRAME_BITS) begin
            lnk_sh_q  <= {lnk_sh_q[30:0], lnk_si_i};
            lnk_len_q <= lnk_cnt_q + 6'h01;
        end
    end

    // -------------------------------------------------------------
    // crossing: select rise qualifies the frozen shift word
    // -------------------------------------------------------------
    logic        cs_s1_q;
    logic        cs_s2_q;
    logic        cs_s3_q;
    logic        ev_q;
    logic [7:0]  opc_q;
    logic [23:0] adr_q;
    logic        full_q;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
        end else begin
            cs_s1_q <= lnk_cs_n_i;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
        end
    end

    // sck is idle once select is seen high twice, so the word is stable
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ev_q   <= 1'b0;
            opc_q  <= 8'h00;
            adr_q  <= 24'h000000;
            full_q <= 1'b0;
        end else begin
            ev_q <= cs_s2_q && !cs_s3_q && lnk_len_q >= 6'(OPC_BITS);
            if (cs_s2_q && !cs_s3_q) begin
                full_q <= lnk_len_q == FRAME_BITS;
                adr_q  <= lnk_sh_q[ADDR_BITS-1:0];
                opc_q  <= (lnk_len_q == FRAME_BITS) ? lnk_sh_q[31:24]
                                                    : lnk_sh_q[7:0];
            end
        end
    end

    // -------------------------------------------------------------
    // command admission
    // -------------------------------------------------------------
    fsr_state_t  st_q;
    fsr_op_t     op_q;
    logic        prog_susp_q;
    logic        erase_susp_q;
    logic        check_susp_q;
    logic        wel_q;
    logic [15:0] lat_q;
    logic [23:0] prog_adr_q;
    logic [23:0] sect_adr_q;
    logic        busy;
    logic        any_susp;
    logic        pc_susp;
    logic        take;
    logic        last_lat;

    assign busy     = st_q != ST_IDLE;
    assign any_susp = prog_susp_q | erase_susp_q | check_susp_q;
    assign pc_susp  = prog_susp_q | check_susp_q;
    assign last_lat = lat_q == 16'(SUSP_LAT_CYC - 1);

    always_comb begin
        take = 1'b0;
        case (opc_q)
            OPC_STAT1, OPC_STAT2, OPC_CFG1, OPC_LOCKB: begin
                take = 1'b1;
            end
            OPC_WREN, OPC_WRENV, OPC_WRDI: begin
                take = !pc_susp;
            end
            OPC_PROG, OPC_SPROG: begin
                take = full_q && !busy && wel_q && !pc_susp;
            end
            OPC_SERASE, OPC_CERASE: begin
                take = (opc_q == OPC_CERASE || full_q) && !busy
                       && wel_q && !any_susp;
            end
            OPC_CHECK: begin
                take = !busy && !any_susp;
            end
            OPC_REGWR, OPC_PLERA: begin
                take = !busy && wel_q && !any_susp;
            end
            OPC_READ, OPC_DYBRD: begin
                take = full_q && !busy;
            end
            OPC_SREAD: begin
                take = full_q && !busy && !check_susp_q;
            end
            OPC_SUSP: begin
                // chip erase and idle are left alone
                take = st_q == ST_RUN && op_q != OP_CERASE
                       && op_q != OP_NONE;
            end
            OPC_RESUME: begin
                take = !busy && any_susp;
            end
            default: begin
                take = 1'b0;
            end
        endcase
    end

    // -------------------------------------------------------------
    // operation sequencer
    // -------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_q         <= ST_IDLE;
            op_q         <= OP_NONE;
            prog_susp_q  <= 1'b0;
            erase_susp_q <= 1'b0;
            check_susp_q <= 1'b0;
            lat_q        <= 16'h0000;
            prog_adr_q   <= 24'h000000;
            sect_adr_q   <= 24'h000000;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (ev_q && take) begin
                        case (opc_q)
                            OPC_PROG, OPC_SPROG: begin
                                st_q       <= ST_RUN;
                                op_q       <= OP_PROG;
                                prog_adr_q <= adr_q;
                            end
                            OPC_SERASE: begin
                                st_q       <= ST_RUN;
                                op_q       <= OP_SERASE;
                                sect_adr_q <= adr_q;
                            end
                            OPC_CERASE: begin
                                st_q <= ST_RUN;
                                op_q <= OP_CERASE;
                            end
                            OPC_CHECK: begin
                                st_q <= ST_RUN;
                                op_q <= OP_CHECK;
                            end
                            OPC_RESUME: begin
                                st_q <= ST_RUN;
                                if (prog_susp_q) begin
                                    op_q        <= OP_PROG;
                                    prog_susp_q <= 1'b0;
                                end else if (erase_susp_q) begin
                                    op_q         <= OP_SERASE;
                                    erase_susp_q <= 1'b0;
                                end else begin
                                    op_q         <= OP_CHECK;
                                    check_susp_q <= 1'b0;
                                end
                            end
                            default: begin
                                st_q <= ST_IDLE;
                            end
                        endcase
                    end
                end
                ST_RUN: begin
                    if (op_done_i) begin
                        // erase flag untouched: nested program falls back
                        st_q <= ST_IDLE;
                        op_q <= OP_NONE;
                    end else if (ev_q && take && opc_q == OPC_SUSP) begin
                        st_q  <= ST_STOP;
                        lat_q <= 16'h0000;
                    end
                end
                ST_STOP: begin
                    lat_q <= lat_q + 16'h0001;
                    if (op_done_i) begin
                        // finished before it could stop: completed
                        st_q <= ST_IDLE;
                        op_q <= OP_NONE;
                    end else if (last_lat) begin
                        st_q         <= ST_IDLE;
                        op_q         <= OP_NONE;
                        prog_susp_q  <= prog_susp_q  | (op_q == OP_PROG);
                        erase_susp_q <= erase_susp_q | (op_q == OP_SERASE);
                        check_susp_q <= check_susp_q | (op_q == OP_CHECK);
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                    op_q <= OP_NONE;
                end
            endcase
        end
    end

    // -------------------------------------------------------------
    // write enable latch
    // -------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            wel_q <= 1'b0;
        end else if (ev_q && take) begin
            case (opc_q)
                OPC_WREN, OPC_WRENV: begin
                    wel_q <= 1'b1;
                end
                OPC_WRDI, OPC_PROG, OPC_SPROG, OPC_SERASE,
                OPC_CERASE, OPC_REGWR, OPC_PLERA: begin
                    wel_q <= 1'b0;
                end
                default: begin
                    wel_q <= wel_q;
                end
            endcase
        end
    end

    // -------------------------------------------------------------
    // results and status outputs
    // -------------------------------------------------------------
    logic page_hit;
    logic sect_hit;

    assign page_hit = adr_q[23:PAGE_BITS] == prog_adr_q[23:PAGE_BITS];
    assign sect_hit = adr_q[23:SECT_BITS] == sect_adr_q[23:SECT_BITS];

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cmd_taken_o      <= 1'b0;
            cmd_refused_o    <= 1'b0;
            cmd_code_o       <= 8'h00;
            read_undefined_o <= 1'b0;
        end else begin
            cmd_taken_o   <= ev_q && take;
            cmd_refused_o <= ev_q && !take;
            if (ev_q) begin
                cmd_code_o       <= opc_q;
                read_undefined_o <= take && opc_q == OPC_READ
                    && ((prog_susp_q && page_hit)
                    || (erase_susp_q && sect_hit));
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            first_status_volatile_o  <= STAT_RST;
            second_status_volatile_o <= STAT_RST;
            engine_run_o             <= 1'b0;
            engine_halt_o            <= 1'b0;
            engine_kind_o            <= 3'h0;
            engine_addr_o            <= 24'h000000;
        end else begin
            first_status_volatile_o           <= STAT_RST;
            first_status_volatile_o[ST1_BUSY] <= busy;
            second_status_volatile_o            <= STAT_RST;
            second_status_volatile_o[ST2_PROG]  <= prog_susp_q;
            second_status_volatile_o[ST2_ERASE] <= erase_susp_q;
            second_status_volatile_o[ST2_CHECK] <= check_susp_q;
            engine_run_o  <= st_q == ST_RUN;
            engine_halt_o <= st_q == ST_STOP;
            engine_kind_o <= op_q;
            engine_addr_o <= (op_q == OP_PROG) ? prog_adr_q : sect_adr_q;
        end
    end

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_susp_ev;
        ev_q && opc_q == OPC_SUSP;
    endsequence

    sequence s_stop_end;
        st_q == ST_STOP && last_lat && !op_done_i;
    endsequence

    a_idle_susp_ign: assert property (s_susp_ev and st_q == ST_IDLE
        |=> $stable(any_susp) && st_q == ST_IDLE && cmd_refused_o)
        else $error("suspend while idle changed state");

    a_chip_no_susp: assert property (s_susp_ev and st_q == ST_RUN
        && op_q == OP_CERASE && !op_done_i |=> st_q == ST_RUN)
        else $error("chip erase was suspended");

    a_susp_lat_cap: assert property (st_q == ST_STOP
        |-> lat_q < 16'(SUSP_LAT_CYC))
        else $error("suspend latency exceeded");

    a_prog_flag_set: assert property (s_stop_end and op_q == OP_PROG
        |=> prog_susp_q && !busy ##1 second_status_volatile_o[ST2_PROG])
        else $error("program suspend flag not set");

    a_erase_flag_set: assert property (s_stop_end and op_q == OP_SERASE
        |=> erase_susp_q ##1 second_status_volatile_o[ST2_ERASE])
        else $error("erase suspend flag not set");

    a_check_flag_set: assert property (s_stop_end and op_q == OP_CHECK
        |=> check_susp_q ##1 second_status_volatile_o[ST2_CHECK])
        else $error("check suspend flag not set");

    a_resume_order: assert property (ev_q && opc_q == OPC_RESUME && !busy
        && prog_susp_q |=> st_q == ST_RUN && op_q == OP_PROG
        ##1 first_status_volatile_o[ST1_BUSY])
        else $error("resume did not restart program");

    a_erase_refused: assert property (ev_q && any_susp
        && (opc_q == OPC_SERASE || opc_q == OPC_CERASE)
        |=> cmd_refused_o && !cmd_taken_o && $stable(sect_adr_q))
        else $error("erase accepted during suspend");

    a_regwr_refused: assert property (ev_q && any_susp
        && (opc_q == OPC_REGWR || opc_q == OPC_PLERA) |=> cmd_refused_o)
        else $error("register write accepted during suspend");

    a_wren_refused: assert property (ev_q && pc_susp
        && (opc_q == OPC_WREN || opc_q == OPC_PROG) |=> cmd_refused_o)
        else $error("write command accepted in program suspend");

    a_status_rd_ok: assert property (ev_q && (opc_q == OPC_STAT1
        || opc_q == OPC_STAT2 || opc_q == OPC_LOCKB) |=> cmd_taken_o)
        else $error("status read refused");

    a_page_undef: assert property (ev_q && opc_q == OPC_READ && full_q
        && !busy && prog_susp_q && page_hit |=> read_undefined_o)
        else $error("read in suspended page not flagged");

    a_back_erase_susp: assert property (st_q == ST_RUN && op_done_i
        && erase_susp_q |=> erase_susp_q && st_q == ST_IDLE)
        else $error("nested program lost erase suspend");

endmodule : fsr_ctrl

`default_nettype wire

/* File: tb/fsr_host_model.sv */
// host link model: drives serial frames onto the select, clock and data lines
`default_nettype none

module fsr_host_model (
    // serial link
    output logic lnk_sck_o,
    output logic lnk_cs_n_o,
    output logic lnk_si_o
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        lnk_sck_o  = 1'b0;
        lnk_cs_n_o = 1'b1;
        lnk_si_o   = 1'b0;
    end

    // msb first, 12 ns link clock only inside the frame
    task automatic send(input logic [31:0] frame, input int nbits);
        int i;
        lnk_cs_n_o = 1'b0;
        for (i = nbits - 1; i >= 0; i--) begin
            lnk_si_o = frame[i];
            #6 lnk_sck_o = 1'b1;
            #6 lnk_sck_o = 1'b0;
        end
        #6 lnk_cs_n_o = 1'b1;
        // released line no longer shows the last bit
        lnk_si_o = ~lnk_si_o;
    endtask : send
endmodule : fsr_host_model

`default_nettype wire

/* File: tb/fsr_ctrl_tb_top.sv */
// self-checking bench for the suspend/resume controller
`default_nettype none

module fsr_ctrl_tb_top
    import fsr_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk_i       = 1'b0;
    logic        sys_rst_i   = 1'b1;
    logic        op_done_i   = 1'b0;
    logic        sck, cs_n, si, run, halt, taken, refused, undef;
    logic [2:0]  kind;
    logic [7:0]  code, st1, st2;
    logic [23:0] addr;
    int          bad_count   = 0;
    int          check_count = 0;
    logic [7:0]  nope [9]    = '{OPC_WRDI, OPC_WREN, OPC_WRENV, OPC_PROG, OPC_SPROG,
                                 OPC_REGWR, OPC_PLERA, OPC_SERASE, OPC_CERASE};
    logic [7:0]  yes  [5]    = '{OPC_STAT1, OPC_STAT2, OPC_CFG1, OPC_LOCKB, OPC_SREAD};

    always #4 clk_i = ~clk_i;

    fsr_host_model i_host (.lnk_sck_o(sck), .lnk_cs_n_o(cs_n), .lnk_si_o(si));

    fsr_ctrl #(.SUSP_LAT_CYC(20)) i_dut (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .lnk_sck_i(sck), .lnk_cs_n_i(cs_n),
        .lnk_si_i(si), .op_done_i(op_done_i), .engine_run_o(run), .engine_halt_o(halt),
        .engine_kind_o(kind), .engine_addr_o(addr), .cmd_taken_o(taken),
        .cmd_refused_o(refused), .cmd_code_o(code), .read_undefined_o(undef),
        .first_status_volatile_o(st1), .second_status_volatile_o(st2));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude();
        if (bad_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude

    function automatic int len(input logic [7:0] o);
        return (o == OPC_PROG || o == OPC_SPROG || o == OPC_SERASE || o == OPC_READ ||
                o == OPC_DYBRD || o == OPC_SREAD) ? 32 : 8;
    endfunction : len

    task automatic cmd(input logic [7:0] opc, input logic [23:0] a, input logic ok);
        int k;
        i_host.send((len(opc) == 8) ? {24'h0, opc} : {opc, a}, len(opc));
        for (k = 0; k < 20 && taken !== 1'b1 && refused !== 1'b1; k++) begin
            @(posedge clk_i) #1;
        end
        if (k == 20) begin
            check(8'h01, 8'h00);
            conclude();
        end
        check({7'h0, taken}, {7'h0, ok});
        check({7'h0, refused}, {7'h0, ~ok});
        check(code, opc);
        // settle past the edge so callers never sample a launching edge
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
    endtask : cmd

    task automatic wait_busy(input logic b, input int lim);
        int k;
        for (k = 0; k < lim && st1[ST1_BUSY] !== b; k++) begin
            @(posedge clk_i) #1;
        end
        if (k == lim) begin
            check(8'h02, 8'h00);
            conclude();
        end
    endtask : wait_busy

    task automatic susp(input logic [7:0] exp);
        cmd(OPC_SUSP, 24'h0, 1'b1);
        check({7'h0, halt}, 8'h01);
        wait_busy(1'b0, 24);
        check({7'h0, halt}, 8'h00);
        check(st2, exp);
    endtask : susp

    task automatic resume_k(input logic [2:0] k);
        cmd(OPC_RESUME, 24'h0, 1'b1);
        wait_busy(1'b1, 4);
        check({7'h0, run}, 8'h01);
        check({5'h0, kind}, {5'h0, k});
    endtask : resume_k

    task automatic done();
        @(negedge clk_i) op_done_i = 1'b1;
        @(negedge clk_i) op_done_i = 1'b0;
        wait_busy(1'b0, 8);
    endtask : done

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_idle();
        cmd(OPC_SUSP, 24'h0, 1'b0);
        check(st2, STAT_RST);
        cmd(OPC_RESUME, 24'h0, 1'b0);
        check(st1, STAT_RST);
    endtask : t_idle

    task automatic t_prog();
        cmd(OPC_WREN, 24'h0, 1'b1);
        cmd(OPC_PROG, 24'h000100, 1'b1);
        wait_busy(1'b1, 4);
        susp(8'h01 << ST2_PROG);
        cmd(OPC_READ, 24'h000180, 1'b1);
        check({7'h0, undef}, 8'h01);
        cmd(OPC_READ, 24'h000300, 1'b1);
        check({7'h0, undef}, 8'h00);
        foreach (nope[i]) cmd(nope[i], 24'h000400, 1'b0);
        foreach (yes[i]) cmd(yes[i], 24'h000400, 1'b1);
        resume_k(OP_PROG);
        check(st2, STAT_RST);
        check(addr[15:8], 8'h01);
        done();
    endtask : t_prog

    task automatic t_erase();
        cmd(OPC_WREN, 24'h0, 1'b1);
        cmd(OPC_SERASE, 24'h040000, 1'b1);
        wait_busy(1'b1, 4);
        susp(8'h01 << ST2_ERASE);
        cmd(OPC_READ, 24'h040010, 1'b1);
        check({7'h0, undef}, 8'h01);
        cmd(OPC_READ, 24'h080000, 1'b1);
        check({7'h0, undef}, 8'h00);
        cmd(OPC_DYBRD, 24'h040000, 1'b1);
        cmd(OPC_WREN, 24'h0, 1'b1);
        cmd(OPC_REGWR, 24'h0, 1'b0);
        cmd(OPC_PLERA, 24'h0, 1'b0);
        cmd(OPC_SERASE, 24'h0c0000, 1'b0);
        cmd(OPC_PROG, 24'h100000, 1'b1);
        wait_busy(1'b1, 4);
        susp((8'h01 << ST2_PROG) | (8'h01 << ST2_ERASE));
        resume_k(OP_PROG);
        check(addr[23:16], 8'h10);
        done();
        check(st2, 8'h01 << ST2_ERASE);
        resume_k(OP_SERASE);
        check(addr[23:16], 8'h04);
        done();
        check(st2, STAT_RST);
    endtask : t_erase

    task automatic t_chip();
        cmd(OPC_WREN, 24'h0, 1'b1);
        cmd(OPC_CERASE, 24'h0, 1'b1);
        wait_busy(1'b1, 4);
        cmd(OPC_SUSP, 24'h0, 1'b0);
        check(st1, 8'h01 << ST1_BUSY);
        done();
        check(st2, STAT_RST);
    endtask : t_chip

    task automatic t_check();
        cmd(OPC_CHECK, 24'h0, 1'b1);
        wait_busy(1'b1, 4);
        susp(8'h01 << ST2_CHECK);
        cmd(OPC_READ, 24'h200000, 1'b1);
        cmd(OPC_WREN, 24'h0, 1'b0);
        cmd(OPC_STAT2, 24'h0, 1'b1);
        resume_k(OP_CHECK);
        repeat (8) @(posedge clk_i);
        susp(8'h01 << ST2_CHECK);
        resume_k(OP_CHECK);
        done();
        check(st2, STAT_RST);
    endtask : t_check

    // program finishes while still halting: counts as completed
    task automatic t_late();
        cmd(OPC_WREN, 24'h0, 1'b1);
        cmd(OPC_PROG, 24'h000200, 1'b1);
        wait_busy(1'b1, 4);
        cmd(OPC_SUSP, 24'h0, 1'b1);
        done();
        check(st2, STAT_RST);
    endtask : t_late

    initial begin
        repeat (6) @(posedge clk_i);
        @(negedge clk_i) sys_rst_i = 1'b0;
        repeat (4) @(posedge clk_i);
        t_idle();
        t_prog();
        t_erase();
        t_chip();
        t_check();
        t_late();
        conclude();
    end
endmodule : fsr_ctrl_tb_top

`default_nettype wire
